/* File: acc_decoder_defs.svh */
// Opcode patterns, field positions and reset values for the decoder
`ifndef ACC_DECODER_DEFS_SVH
`define ACC_DECODER_DEFS_SVH

// ==========================================================
// Fully fixed words and opcode fields
`define OPC_ABSVAL        16'h7F88
`define OPC_ZERO          16'h7F89
`define NIB_ADD           4'h0
`define NIB_SUB           4'h1
`define NIB_LOAD          4'h2
`define BYTE_ADD_HI       8'h60
`define BYTE_ADD_UNS      8'h61
`define BYTE_SUB_HI       8'h62
`define BYTE_SUB_UNS      8'h63
`define BYTE_SUB_COND     8'h64
`define BYTE_LOAD_HI      8'h65
`define BYTE_LOAD_LO      8'h66
`define BYTE_XOR          8'h78
`define BYTE_AND          8'h79
`define BYTE_OR           8'h7A
`define BYTE_LOAD_CONST   8'h7E
`define BYTE_STORE_LO     8'h50
`define TOP5_STORE_HI     5'h0B
`define TOP7_PTR_LOAD     7'h1C
`define TOP7_PTR_STORE    7'h18
`define TOP7_PTR_CONST    7'h38
`define BYTE_MODIFY       8'h68
`define BYTE_PAGE_LOAD    8'h6F
`define TOP15_PAGE_CONST  15'h3700

// ==========================================================
// Field positions inside the instruction word
`define F_ARSEL           8
`define F_MODE            7
`define F_INC             5
`define F_DEC             4
`define F_KEEP            3
`define F_SEL             0

// ==========================================================
// Store shift codes and their amounts, conditional subtract
`define SST_CODE_ONE      3'h1
`define SST_CODE_FOUR     3'h4
`define SST_AMT_ZERO      3'h0
`define SST_AMT_ONE       3'h1
`define SST_AMT_FOUR      3'h4
`define CONDITIONAL_SUB_OP_SHIFT        15

// ==========================================================
// Reset values
`define RST_ACC           32'h0000_0000
`define RST_PTR           16'h0000
`define RST_BIT           1'b0

`endif

/* File: acc_decoder_pkg.sv */
// Types shared by the accumulator and pointer-register decoder
package acc_decoder_pkg;

    typedef enum logic [4:0] {
        no_match_op          = 5'h00,
        absolute_value_op    = 5'h01,
        clear_accum_op       = 5'h02,
        add_shift_op         = 5'h03,
        sub_shift_op         = 5'h04,
        load_shift_op        = 5'h05,
        add_high_half_op     = 5'h06,
        add_unsigned_op      = 5'h07,
        sub_high_half_op     = 5'h08,
        sub_unsigned_op      = 5'h09,
        conditional_sub_op   = 5'h0A,
        clear_load_high_op   = 5'h0B,
        clear_load_low_op    = 5'h0C,
        xor_op               = 5'h0D,
        and_op               = 5'h0E,
        or_op                = 5'h0F,
        load_accum_const_op  = 5'h10,
        store_low_half_op    = 5'h11,
        store_high_half_op   = 5'h12,
        load_pointer_reg_op  = 5'h13,
        store_pointer_reg_op = 5'h14,
        load_pointer_const_op= 5'h15,
        modify_pointer_op    = 5'h16,
        load_page_op         = 5'h17,
        load_page_const_op   = 5'h18
    } op_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic        rd;
        logic        wr;
        logic [15:0] wdata;
    } mem_t;

endpackage

/* File: operand_shifter.sv */
// Operand alignment for accumulator arithmetic and loads
`timescale 1ns/1ps
`default_nettype none
module operand_shifter
    import acc_decoder_pkg::*;
(
    input  wire logic [15:0] i_data,     // Data word
    input  wire logic [3:0]  i_shift,    // Left shift 0..15
    input  wire logic        i_unsigned, // Zero-extend, no shift
    input  wire logic        i_high,     // Place in upper half
    output logic      [31:0] o_value     // Aligned operand
);
    wire logic [31:0] sext = {{16{i_data[15]}}, i_data};
    wire logic [31:0] shl  = sext << i_shift; // see [RULE17]
    wire logic [31:0] zext = {16'h0000, i_data}; // see [RULE5]
    wire logic [31:0] high = {i_data, 16'h0000};

    assign o_value = i_high ? high : (i_unsigned ? zext : shl);
endmodule
`default_nettype wire

/* File: store_shifter.sv */
// Upper-half store alignment of the accumulator
`timescale 1ns/1ps
`default_nettype none
`include "acc_decoder_defs.svh"
module store_shifter
    import acc_decoder_pkg::*;
(
    input  wire logic [31:0] i_accum, // Accumulator
    input  wire logic [2:0]  i_code,  // Store shift code
    output logic      [15:0] o_word   // Word to memory
);
    // Codes other than one and four fall back to no shift
    wire logic [2:0] amt =
        (i_code == `SST_CODE_ONE)  ? `SST_AMT_ONE  :
        (i_code == `SST_CODE_FOUR) ? `SST_AMT_FOUR : `SST_AMT_ZERO;
    wire logic [31:0] shl = i_accum << amt; // see [RULE18]

    assign o_word = shl[31:16];
endmodule
`default_nettype wire

/* File: acc_decoder.sv */
// Accumulator and pointer-register instruction decoder and executor
// Behaviour
// [RULE1] One word, one cycle, no wait cycles
// [RULE2] Fixed words: absolute value, clear accumulator
// [RULE3] Top nibble 0/1/2: add, subtract, load shifted
// [RULE4] 0x60/0x62/0x65: high-half add, subtract, load
// [RULE5] 0x61/0x63/0x66: zero-extended low-half operations
// [RULE6] 0x64: conditional subtract step for division
// [RULE7] 0x78/0x79/0x7A: XOR, AND, OR with memory
// [RULE8] 0x7E: load accumulator from 8-bit constant
// [RULE9] 0x50 stores low half; 01011 stores shifted high
// [RULE10] Pointer register load and store, bit 8 selects
// [RULE11] 0111000 loads pointer register with constant
// [RULE12] 0x68 modifies pointers; 0x6880/1 sets selector
// [RULE13] 0x6F loads page; 0x6E00/1 loads page constant
// [RULE14] Bit 7 mode, bits 6..0 address or control
// [RULE15] Direct address is page joined with seven bits
// [RULE16] Indirect: selected pointer, step, reload selector
// [RULE17] Operand shift 0..15, sign-extended, zero-filled
// [RULE18] Store shift of upper half by 0, 1, 4
// [RULE19] Unmatched words change no accumulator or pointer
`timescale 1ns/1ps
`default_nettype none
`include "acc_decoder_defs.svh"
module acc_decoder
    import acc_decoder_pkg::*;
(
    input  wire logic        i_clk,         // 125 MHz clock
    input  wire logic        i_srst,        // Sync reset, high
    input  wire logic        i_instr_valid, // Instruction present
    input  wire logic [15:0] i_instr,       // Instruction word
    input  wire logic [15:0] i_operand,     // Data word read
    output logic             o_done,        // Instruction retired
    output logic             o_unmatched,   // Word not decoded
    output op_t              o_op,          // Retired operation
    output mem_t             o_mem,         // Memory access made
    output logic      [31:0] o_accum,       // Accumulator
    output logic      [15:0] o_ptr_zero,    // Pointer register 0
    output logic      [15:0] o_ptr_one,     // Pointer register 1
    output logic             o_ptr_select,  // Pointer selector
    output logic             o_page         // Data page pointer
);

    // ======================================================
    // State
    logic [31:0] accumulator_reg_r;
    logic [31:0] accumulator_reg_nxt;
    logic [15:0] ptr_r [2];
    logic [15:0] ptr_nxt [2];
    logic        pointer_select_r;
    logic        page_r;
    logic        done_r;
    logic        unmatched_r;
    op_t         op_r;
    mem_t        mem_r;

    // ======================================================
    // Field extraction
    wire logic [7:0] ub    = i_instr[15:8];
    wire logic [3:0] nib   = i_instr[15:12];
    wire logic [3:0] shamt = i_instr[11:8]; // see [RULE3]
    wire logic       mode  = i_instr[`F_MODE]; // see [RULE14]
    wire logic [6:0] field = i_instr[6:0];
    wire logic [7:0] imm   = i_instr[7:0];
    wire logic       arsel = i_instr[`F_ARSEL]; // see [RULE10]
    wire logic       sel_b = i_instr[`F_SEL];

    // ======================================================
    // Opcode matching
    wire logic hit_abs   = i_instr == `OPC_ABSVAL; // see [RULE2]
    wire logic hit_zero  = i_instr == `OPC_ZERO;
    wire logic hit_add   = nib == `NIB_ADD;        // see [RULE3]
    wire logic hit_sub   = nib == `NIB_SUB;
    wire logic hit_lac   = nib == `NIB_LOAD;
    wire logic hit_addhi = ub == `BYTE_ADD_HI;     // see [RULE4]
    wire logic hit_subhi = ub == `BYTE_SUB_HI;
    wire logic hit_ldhi  = ub == `BYTE_LOAD_HI;
    wire logic hit_addu  = ub == `BYTE_ADD_UNS;    // see [RULE5]
    wire logic hit_subu  = ub == `BYTE_SUB_UNS;
    wire logic hit_ldlo  = ub == `BYTE_LOAD_LO;
    wire logic hit_csub  = ub == `BYTE_SUB_COND;   // see [RULE6]
    wire logic hit_xor   = ub == `BYTE_XOR;        // see [RULE7]
    wire logic hit_and   = ub == `BYTE_AND;
    wire logic hit_or    = ub == `BYTE_OR;
    wire logic hit_lconst= ub == `BYTE_LOAD_CONST; // see [RULE8]
    wire logic hit_stlo  = ub == `BYTE_STORE_LO;   // see [RULE9]
    wire logic hit_sthi  = i_instr[15:11] == `TOP5_STORE_HI;
    wire logic hit_pld   = i_instr[15:9] == `TOP7_PTR_LOAD;
    wire logic hit_pst   = i_instr[15:9] == `TOP7_PTR_STORE;
    wire logic hit_pk    = i_instr[15:9] == `TOP7_PTR_CONST;
    wire logic hit_mod   = ub == `BYTE_MODIFY;     // see [RULE12]
    wire logic hit_pg    = ub == `BYTE_PAGE_LOAD;  // see [RULE13]
    wire logic hit_pgk   = i_instr[15:1] == `TOP15_PAGE_CONST;

    // Fixed words are tested before the byte they share
    wire op_t op_dec =
        hit_abs    ? absolute_value_op     :
        hit_zero   ? clear_accum_op        :
        hit_add    ? add_shift_op          :
        hit_sub    ? sub_shift_op          :
        hit_lac    ? load_shift_op         :
        hit_addhi  ? add_high_half_op      :
        hit_addu   ? add_unsigned_op       :
        hit_subhi  ? sub_high_half_op      :
        hit_subu   ? sub_unsigned_op       :
        hit_csub   ? conditional_sub_op    :
        hit_ldhi   ? clear_load_high_op    :
        hit_ldlo   ? clear_load_low_op     :
        hit_xor    ? xor_op                :
        hit_and    ? and_op                :
        hit_or     ? or_op                 :
        hit_lconst ? load_accum_const_op   :
        hit_stlo   ? store_low_half_op     :
        hit_sthi   ? store_high_half_op    :
        hit_pld    ? load_pointer_reg_op   :
        hit_pst    ? store_pointer_reg_op  :
        hit_pk     ? load_pointer_const_op :
        hit_mod    ? modify_pointer_op     :
        hit_pg     ? load_page_op          :
        hit_pgk    ? load_page_const_op    : no_match_op;

    wire logic no_mem  = hit_abs | hit_zero | hit_lconst | hit_pk
                       | hit_pgk | (op_dec == no_match_op);
    wire logic mem_ref = ~no_mem;
    wire logic is_st   = hit_stlo | hit_sthi | hit_pst;
    wire logic go      = i_instr_valid;
    wire logic indir   = go & mem_ref & mode; // see [RULE16]

    // ======================================================
    // Address formation
    wire logic [15:0] cur_ptr = ptr_r[pointer_select_r];
    wire logic [7:0]  eff_addr =
        mode ? cur_ptr[7:0] : {page_r, field}; // see [RULE15]

    // ======================================================
    // Datapath helpers
    wire logic [31:0] opv;
    wire logic [15:0] st_hi;
    wire logic        op_uns  = hit_addu | hit_subu | hit_ldlo;
    wire logic        op_high = hit_addhi | hit_subhi | hit_ldhi;

    operand_shifter u_opsh (
        .i_data     (i_operand),
        .i_shift    (shamt),
        .i_unsigned (op_uns),
        .i_high     (op_high),
        .o_value    (opv)
    );

    store_shifter u_stsh (
        .i_accum (accumulator_reg_r),
        .i_code  (i_instr[10:8]),
        .o_word  (st_hi)
    );

    wire logic [31:0] zx_op = {16'h0000, i_operand};
    wire logic [31:0] sc_op = zx_op << `CONDITIONAL_SUB_OP_SHIFT;
    wire logic [31:0] sc_df = accumulator_reg_r - sc_op;
    wire logic [31:0] neg   = 32'h0000_0000 - accumulator_reg_r;
    wire logic [31:0] sum   = accumulator_reg_r + opv;
    wire logic [31:0] dif   = accumulator_reg_r - opv;

    // ======================================================
    // Accumulator next value
    always_comb begin
        accumulator_reg_nxt = accumulator_reg_r; // see [RULE19]
        if (go) begin
            case (op_dec)
                absolute_value_op:                    // see [RULE2]
                    accumulator_reg_nxt = accumulator_reg_r[31] ?
                                          neg : accumulator_reg_r;
                clear_accum_op:
                    accumulator_reg_nxt = `RST_ACC;
                add_shift_op, add_high_half_op, add_unsigned_op:
                    accumulator_reg_nxt = sum;       // see [RULE4]
                sub_shift_op, sub_high_half_op, sub_unsigned_op:
                    accumulator_reg_nxt = dif;       // see [RULE5]
                load_shift_op, clear_load_high_op, clear_load_low_op:
                    accumulator_reg_nxt = opv;       // see [RULE3]
                conditional_sub_op:                  // see [RULE6]
                    accumulator_reg_nxt = sc_df[31] ?
                        {accumulator_reg_r[30:0], 1'b0} :
                        {sc_df[30:0], 1'b1};
                xor_op:                              // see [RULE7]
                    accumulator_reg_nxt = accumulator_reg_r ^ zx_op;
                and_op:
                    accumulator_reg_nxt = accumulator_reg_r & zx_op;
                or_op:
                    accumulator_reg_nxt = accumulator_reg_r | zx_op;
                load_accum_const_op:                 // see [RULE8]
                    accumulator_reg_nxt = {24'h000000, imm};
                default:
                    accumulator_reg_nxt = accumulator_reg_r;
            endcase
        end
    end

    // ======================================================
    // Pointer registers; a load wins over an indirect step
    wire logic step_inc = i_instr[`F_INC];
    wire logic step_dec = i_instr[`F_DEC];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ptr
            wire logic mine  = arsel == 1'(gi);
            wire logic cur   = pointer_select_r == 1'(gi);
            wire logic [15:0] stepped = ptr_r[gi]
                + {15'h0000, step_inc} - {15'h0000, step_dec};
            assign ptr_nxt[gi] =
                (go & hit_pld & mine) ? i_operand :       // see [RULE10]
                (go & hit_pk & mine)  ? {8'h00, imm} :    // see [RULE11]
                (indir & cur)         ? stepped :         // see [RULE16]
                ptr_r[gi];
            always_ff @(posedge i_clk) begin
                if (i_srst)
                    ptr_r[gi] <= `RST_PTR;
                else
                    ptr_r[gi] <= ptr_nxt[gi];
            end
        end
    endgenerate

    wire logic sel_nxt = (indir & ~i_instr[`F_KEEP]) ?
                         sel_b : pointer_select_r;    // see [RULE12]
    wire logic page_nxt =
        (go & hit_pg)  ? i_operand[0] :               // see [RULE13]
        (go & hit_pgk) ? sel_b : page_r;

    // ======================================================
    // Memory access report
    wire mem_t mem_nxt = '{
        addr:  (go & mem_ref) ? eff_addr : 8'h00,
        rd:    go & mem_ref & ~is_st & ~hit_mod,
        wr:    go & is_st,
        wdata: hit_stlo ? accumulator_reg_r[15:0] :   // see [RULE9]
               hit_sthi ? st_hi :
               hit_pst  ? ptr_r[arsel] : 16'h0000
    };

    // ======================================================
    // Registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            accumulator_reg_r <= `RST_ACC;
            pointer_select_r  <= `RST_BIT;
            page_r            <= `RST_BIT;
            done_r            <= `RST_BIT;
            unmatched_r       <= `RST_BIT;
            op_r              <= no_match_op;
            mem_r             <= '0;
        end else begin
            accumulator_reg_r <= accumulator_reg_nxt;
            pointer_select_r  <= sel_nxt;
            page_r            <= page_nxt;
            done_r            <= go;                  // see [RULE1]
            unmatched_r       <= go & (op_dec == no_match_op);
            op_r              <= go ? op_dec : no_match_op;
            mem_r             <= mem_nxt;
        end
    end

    assign o_done       = done_r;
    assign o_unmatched  = unmatched_r;
    assign o_op         = op_r;
    assign o_mem        = mem_r;
    assign o_accum      = accumulator_reg_r;
    assign o_ptr_zero   = ptr_r[0];
    assign o_ptr_one    = ptr_r[1];
    assign o_ptr_select = pointer_select_r;
    assign o_page       = page_r;

    // ======================================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_single_cycle_retire: assert property ( // see [RULE1]
        i_instr_valid |=> o_done ##1 (o_done == $past(i_instr_valid)))
        else $error("instruction did not retire in one cycle");

    a_clear_accum_zero: assert property ( // see [RULE2]
        i_instr_valid && i_instr == `OPC_ZERO |=> o_accum == `RST_ACC)
        else $error("clear did not zero accumulator");

    a_abs_value_result: assert property ( // see [RULE2]
        i_instr_valid && i_instr == `OPC_ABSVAL |=>
        o_accum == ($past(o_accum[31]) ? -$past(o_accum)
                                       : $past(o_accum)))
        else $error("absolute value wrong");

    a_const_load_value: assert property ( // see [RULE8]
        i_instr_valid && hit_lconst |=>
        o_accum == {24'h000000, $past(i_instr[7:0])} && !o_mem.rd)
        else $error("constant load wrong");

    a_store_low_data: assert property ( // see [RULE9]
        i_instr_valid && hit_stlo |=>
        o_mem.wr && o_mem.wdata == $past(o_accum[15:0]))
        else $error("low-half store data wrong");

    a_direct_addr_form: assert property ( // see [RULE15]
        i_instr_valid && mem_ref && !i_instr[`F_MODE] |=>
        o_mem.addr == {$past(o_page), $past(i_instr[6:0])})
        else $error("direct address wrong");

    a_selector_reload: assert property ( // see [RULE16]
        i_instr_valid && mem_ref && i_instr[`F_MODE]
        && !i_instr[`F_KEEP] |=> o_ptr_select == $past(i_instr[0]))
        else $error("selector not reloaded");

    a_const_ptr_load: assert property ( // see [RULE11]
        i_instr_valid && hit_pk && !i_instr[`F_ARSEL] |=>
        o_ptr_zero == {8'h00, $past(i_instr[7:0])})
        else $error("pointer constant load wrong");

    a_page_const_load: assert property ( // see [RULE13]
        i_instr_valid && hit_pgk |=> o_page == $past(i_instr[0]))
        else $error("page constant load wrong");

    a_unmatched_hold: assert property ( // see [RULE19]
        i_instr_valid && op_dec == no_match_op |=>
        $stable(o_accum) && $stable(o_ptr_zero) && $stable(o_ptr_one)
        && o_unmatched ##1 (!o_unmatched || $past(i_instr_valid)))
        else $error("unmatched word changed state");

    c_indirect_step: cover property (
        indir && step_inc ##1 o_done);
    c_store_high: cover property (
        i_instr_valid && hit_sthi ##1 o_mem.wr);
    c_cond_subtract: cover property (
        i_instr_valid && hit_csub [*2]);
    c_back_to_back: cover property (
        i_instr_valid [*4]);

endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the accumulator and pointer decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acc_decoder_pkg::*;
    // ==========================================================
    // Signals and expected state
    logic        i_clk;
    logic        i_srst;
    logic        i_instr_valid;
    logic [15:0] i_instr;
    wire  [15:0] i_operand;
    logic        o_done;
    logic        o_unmatched;
    op_t         o_op;
    mem_t        o_mem;
    logic [31:0] o_accum;
    logic [15:0] o_ptr_zero;
    logic [15:0] o_ptr_one;
    logic        o_ptr_select;
    logic        o_page;
    int          bad_count;
    int          compares;
    logic [31:0] acc_e;
    logic [15:0] p0_e;
    logic [15:0] p1_e;
    logic [15:0] v_e;
    logic [15:0] wd_e;
    logic [7:0]  a_e;
    logic        sel_e;
    logic        page_e;
    logic        um_e;
    logic        rd_e;
    logic        wr_e;
    logic        mem_on;

    acc_decoder i_dut (
        .i_clk        (i_clk),
        .i_srst       (i_srst),
        .i_instr_valid(i_instr_valid),
        .i_instr      (i_instr),
        .i_operand    (i_operand),
        .o_done       (o_done),
        .o_unmatched  (o_unmatched),
        .o_op         (o_op),
        .o_mem        (o_mem),
        .o_accum      (o_accum),
        .o_ptr_zero   (o_ptr_zero),
        .o_ptr_one    (o_ptr_one),
        .o_ptr_select (o_ptr_select),
        .o_page       (o_page)
    );

    // ==========================================================
    // Data memory model and helpers
    function automatic logic [15:0] memval(input logic [7:0] a);
        return {a ^ 8'hC3, a};
    endfunction
    function automatic logic [31:0] sx(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction
    function automatic logic [31:0] zx(input logic [15:0] v);
        return {16'h0000, v};
    endfunction
    function automatic logic [31:0] cond_sub(input logic [15:0] v);
        logic [31:0] diff;
        diff = acc_e - ({16'h0000, v} << 15);
        return diff[31] ? acc_e << 1 : (diff << 1) + 32'h1;
    endfunction

    // Live pointers pick the word, as the device's RAM would
    assign i_operand = memval(i_instr[7] ?
        (o_ptr_select ? o_ptr_one[7:0] : o_ptr_zero[7:0]) :
        {o_page, i_instr[6:0]});

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // Presents a word; steps the expected pointers before the edge
    task automatic go(input logic [15:0] w, input logic mref);
        a_e = w[7] ? (sel_e ? p1_e[7:0] : p0_e[7:0]) : {page_e, w[6:0]};
        v_e = memval(a_e);
        rd_e = mref;
        wr_e = 1'b0;
        if (mref && w[7]) begin
            if (sel_e)
                p1_e = p1_e + 16'(w[5]) - 16'(w[4]);
            else
                p0_e = p0_e + 16'(w[5]) - 16'(w[4]);
            if (!w[3])
                sel_e = w[0];
        end
        i_instr_valid = 1'b1;
        i_instr = w;
    endtask

    task automatic fin(input op_t op, input logic [31:0] acc);
        acc_e = acc;
        @(posedge i_clk);
        #1;
        chk("done", 32'h1, 32'(o_done));
        chk("unmatched", 32'(um_e), 32'(o_unmatched));
        chk("op", 32'(op), 32'(o_op));
        chk("accum", acc_e, o_accum);
        chk("ptr_zero", 32'(p0_e), 32'(o_ptr_zero));
        chk("ptr_one", 32'(p1_e), 32'(o_ptr_one));
        chk("ptr_select", 32'(sel_e), 32'(o_ptr_select));
        chk("page", 32'(page_e), 32'(o_page));
        if (mem_on) begin
            chk("rd", 32'(rd_e), 32'(o_mem.rd));
            chk("wr", 32'(wr_e), 32'(o_mem.wr));
        end
        if (rd_e || wr_e)
            chk("addr", 32'(a_e), 32'(o_mem.addr));
        if (wr_e)
            chk("wdata", 32'(wd_e), 32'(o_mem.wdata));
    endtask

    task automatic st(input logic [15:0] w, input op_t op,
                      input logic [15:0] wd);
        go(w, 1'b1);
        rd_e = 1'b0;
        wr_e = 1'b1;
        wd_e = wd;
        fin(op, acc_e);
    endtask

    task automatic idle();
        i_instr_valid = 1'b0;
        @(posedge i_clk);
        #1;
        chk("done idle", 32'h0, 32'(o_done));
    endtask

    // ==========================================================
    // Scenarios, words back to back; t_arith and t_page each end with one idle cycle
    task automatic t_arith();
        go(16'h6540, 1'b1);
        fin(clear_load_high_op, {v_e, 16'h0000});
        go(16'h6001, 1'b1);
        fin(add_high_half_op, acc_e + {v_e, 16'h0000});
        go(16'h6202, 1'b1);
        fin(sub_high_half_op, acc_e - {v_e, 16'h0000});
        go(16'h6603, 1'b1);
        fin(clear_load_low_op, zx(v_e));
        go(16'h6104, 1'b1);
        fin(add_unsigned_op, acc_e + zx(v_e));
        go(16'h6305, 1'b1);
        fin(sub_unsigned_op, acc_e - zx(v_e));
        go(16'h2F05, 1'b1);
        fin(load_shift_op, sx(v_e) << 15);
        go(16'h0012, 1'b1);
        fin(add_shift_op, acc_e + sx(v_e));
        go(16'h1443, 1'b1);
        fin(sub_shift_op, acc_e - (sx(v_e) << 4));
        idle();
    endtask

    task automatic t_store_logic();
        go(16'h6541, 1'b1);
        fin(clear_load_high_op, {v_e, 16'h0000});
        go(16'h6106, 1'b1);
        fin(add_unsigned_op, acc_e + zx(v_e));
        st(16'h5007, store_low_half_op, acc_e[15:0]);
        st(16'h5807, store_high_half_op, acc_e[31:16]);
        st(16'h5907, store_high_half_op, acc_e[30:15]);
        st(16'h5C07, store_high_half_op, acc_e[27:12]);
        st(16'h5A07, store_high_half_op, acc_e[31:16]);
        go(16'h7F88, 1'b0);
        fin(absolute_value_op, -acc_e);
        go(16'h7F89, 1'b0);
        fin(clear_accum_op, 32'h0000_0000);
        go(16'h6520, 1'b1);
        fin(clear_load_high_op, {v_e, 16'h0000});
        go(16'h7810, 1'b1);
        fin(xor_op, acc_e ^ zx(v_e));
        go(16'h7EA5, 1'b0);
        fin(load_accum_const_op, 32'h0000_00A5);
        go(16'h7A11, 1'b1);
        fin(or_op, acc_e | zx(v_e));
        go(16'h7912, 1'b1);
        fin(and_op, acc_e & zx(v_e));
    endtask

    task automatic t_pointer();
        go(16'h7080, 1'b0);
        p0_e = 16'h0080;
        fin(load_pointer_const_op, acc_e);
        go(16'h71F3, 1'b0);
        p1_e = 16'h00F3;
        fin(load_pointer_const_op, acc_e);
        mem_on = 1'b0;
        go(16'h6881, 1'b1);
        fin(modify_pointer_op, acc_e);
        go(16'h68A8, 1'b1);
        fin(modify_pointer_op, acc_e);
        go(16'h6835, 1'b0);
        fin(modify_pointer_op, acc_e);
        mem_on = 1'b1;
        st(16'h5098, store_low_half_op, acc_e[15:0]);
        go(16'h3890, 1'b1);
        p0_e = v_e;
        fin(load_pointer_reg_op, acc_e);
        st(16'h3108, store_pointer_reg_op, p1_e);
    endtask

    task automatic t_page();
        go(16'h6E01, 1'b0);
        page_e = 1'b1;
        fin(load_page_const_op, acc_e);
        go(16'h0005, 1'b1);
        fin(add_shift_op, acc_e + sx(v_e));
        go(16'h6F00, 1'b1);
        page_e = v_e[0];
        fin(load_page_op, acc_e);
        go(16'h6E01, 1'b0);
        page_e = 1'b1;
        fin(load_page_const_op, acc_e);
        go(16'h7EFF, 1'b0);
        fin(load_accum_const_op, 32'h0000_00FF);
        go(16'h6401, 1'b1);
        fin(conditional_sub_op, cond_sub(v_e));
        go(16'h6505, 1'b1);
        fin(clear_load_high_op, {v_e, 16'h0000});
        go(16'h6401, 1'b1);
        fin(conditional_sub_op, cond_sub(v_e));
        um_e = 1'b1;
        go(16'hF900, 1'b0);
        fin(no_match_op, acc_e);
        go(16'h8000, 1'b0);
        fin(no_match_op, acc_e);
        um_e = 1'b0;
        idle();
    endtask

    // ==========================================================
    // Run control
    task automatic conclude();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // About 55 cycles are needed; the limit leaves wide margin
    initial begin
        #20000;
        bad_count++;
        conclude();
    end

    initial begin
        {i_srst, i_instr_valid, i_instr} = {1'b1, 1'b0, 16'h0000};
        {bad_count, compares} = {32'h0, 32'h0};
        {acc_e, p0_e, p1_e, sel_e, page_e} = '0;
        {um_e, rd_e, wr_e, mem_on} = 4'h1;
        repeat (12) @(posedge i_clk);
        #1;
        chk("accum reset", 32'h0, o_accum);
        chk("done reset", 32'h0, 32'(o_done));
        i_srst = 1'b0;
        t_arith();
        t_store_logic();
        t_pointer();
        t_page();
        conclude();
    end
endmodule
`default_nettype wire
